//--- src/twm_bus_host.sv
// Two-wire bus host: byte-level master that drives the documented device
// Functional notes
// - Bus idle when data and clock high
// - Byte is eight data plus one acknowledge
// - MSB first, any byte count, each acknowledged
// - Wait while receiver holds clock low
// - START/STOP are data edges, clock high
// - First byte: seven address bits, direction
// - Direction zero writes, one reads
// - Data stable while clock high
// - Master clocks ack; transmitter releases data
// - Receiver acknowledges by pulling data low
// - Address not acknowledged: master sends STOP
// - Master receiver leaves last byte unacknowledged
`default_nettype none
module twm_bus_host #(
  parameter int unsigned STD_Q  = twm_pkg::STD_QUARTER,
  parameter int unsigned FAST_Q = twm_pkg::FAST_QUARTER
) (
  // Clock, reset, enable
  input  wire logic       sysClk,
  input  wire logic       rstn,
  input  wire logic       clkEn,
  input  wire logic       fastMode,
  // Command
  input  wire logic       cmdValid,
  output logic            cmdReady,
  input  wire logic       cmdStart,
  input  wire logic       cmdStop,
  input  wire logic       cmdRead,
  input  wire logic       cmdNack,
  input  wire logic [6:0] cmdAddr,
  input  wire logic [7:0] cmdByte,
  // Response
  output logic            rspValid,
  output logic [7:0]      rspByte,
  output logic            rspAck,
  output logic            rspArbLost,
  output logic            busBusy,
  // Bus pins, open drain
  input  wire logic       busClockPinIn,
  output logic            busClockPinOut,
  output logic            busClockPinOe,
  input  wire logic       busDataPinIn,
  output logic            busDataPinOut,
  output logic            busDataPinOe
);
  import twm_pkg::*;

  if (STD_Q < 2 || FAST_Q < 2 || 3 * STD_Q > 255 || 3 * FAST_Q > 255)
  begin : g_chk
    $error("twm_bus_host: quarter counts out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  twm_state_t        state_q, state_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic [3:0]        bitIdx_q, bitIdx_d;
  logic [7:0]        shift_q, shift_d, rspByte_q, rspByte_d;
  logic              rdMode_q, rdMode_d, nackLast_q, nackLast_d;
  logic              stop_q, stop_d, own_q, own_d, busy_q, busy_d;
  logic              sclOe_q, sclOe_d, sdaOe_q, sdaOe_d;
  logic              cmdReady_q, cmdReady_d, rspValid_q, rspValid_d;
  logic              rspAck_q, rspAck_d, rspArb_q, rspArb_d;
  logic              sclMeta_q, sclSync_q, sclPrev_q;
  logic              sdaMeta_q, sdaSync_q, sdaPrev_q;

  // Selection and decoding
  wire [CNT_W-1:0] quarter   = fastMode ? CNT_W'(FAST_Q) : CNT_W'(STD_Q);
  wire [CNT_W-1:0] half      = CNT_W'({quarter, 1'b0});
  wire [CNT_W-1:0] lowLen    = half + quarter;
  wire             atLowEnd  = cntInc == lowLen;
  wire [CNT_W-1:0] cntInc    = cnt_q + CNT_W'(1);
  wire             atQuarter = cntInc == quarter;
  wire             atHalf    = cntInc == half;
  wire             isAck     = bitIdx_q == 4'(ACK_IDX);
  wire             isTail    = bitIdx_q == 4'(TAIL_IDX);
  wire             takeCmd   = cmdValid && cmdReady_q;
  wire             startSeen = sclSync_q && sclPrev_q && sdaPrev_q && !sdaSync_q;
  wire             stopSeen  = sclSync_q && sclPrev_q && !sdaPrev_q && sdaSync_q;
  // Ack bit: transmitter releases, receiver pulls low unless last byte
  wire             driveLow  = isAck ? (rdMode_q && !nackLast_q)
                                     : (!rdMode_q && !shift_q[7]);
  wire             arbLose   = !rdMode_q && !isAck && !sdaOe_q && !sdaSync_q;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    bitIdx_d   = bitIdx_q;
    shift_d    = shift_q;
    rdMode_d   = rdMode_q;
    nackLast_d = nackLast_q;
    stop_d     = stop_q;
    own_d      = own_q;
    sclOe_d    = sclOe_q;
    sdaOe_d    = sdaOe_q;
    rspByte_d  = rspByte_q;
    rspAck_d   = rspAck_q;
    rspArb_d   = rspArb_q;
    rspValid_d = 1'b0;
    busy_d     = busy_q;
    if (startSeen) begin
      busy_d = 1'b1;
    end else if (stopSeen) begin
      busy_d = 1'b0;
    end
    unique case (state_q)
      ST_IDLE: begin
        if (takeCmd) begin
          cnt_d      = '0;
          bitIdx_d   = '0;
          nackLast_d = cmdNack;
          stop_d     = cmdStop;
          if (cmdStart) begin
            shift_d  = {cmdAddr, cmdRead};
            rdMode_d = 1'b0;
            own_d    = 1'b1;
            state_d  = ST_SETUP;
          end else if (own_q) begin
            shift_d  = cmdRead ? BYTE_RESET : cmdByte;
            rdMode_d = cmdRead;
            state_d  = ST_LOW;
          end
        end
      end
      ST_SETUP: begin
        // Restart: data already released, clock released after a quarter
        if (cnt_q != half) cnt_d = cntInc;
        if (atQuarter) sclOe_d = 1'b0;
        if (cnt_q == half && sclSync_q && sdaSync_q) begin
          sdaOe_d = 1'b1;
          cnt_d   = '0;
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        cnt_d = cntInc;
        if (atHalf) begin
          sclOe_d = 1'b1;
          cnt_d   = '0;
          state_d = ST_LOW;
        end
      end
      ST_LOW: begin
        cnt_d = cntInc;
        // Data only moves one quarter into the three-quarter low phase, clear of both clock edges
        if (atQuarter) begin
          if (isTail) begin
            sdaOe_d = 1'b0;
            cnt_d   = '0;
            state_d = stop_q ? ST_PLOW : ST_IDLE;
          end else begin
            sdaOe_d = driveLow;
          end
        end
        if (atLowEnd && !isTail) begin
          sclOe_d = 1'b0;
          cnt_d   = '0;
          state_d = ST_HIGH;
        end
      end
      ST_HIGH: begin
        // A stretched clock stalls the count until the line is high
        if (sclSync_q) cnt_d = cntInc;
        if (sclSync_q && atHalf) begin
          cnt_d = '0;
          if (arbLose) begin
            sdaOe_d    = 1'b0;
            own_d      = 1'b0;
            rspArb_d   = 1'b1;
            rspAck_d   = 1'b0;
            rspValid_d = 1'b1;
            state_d    = ST_IDLE;
          end else begin
            sclOe_d  = 1'b1;
            bitIdx_d = bitIdx_q + 4'(1);
            state_d  = ST_LOW;
            if (isAck) begin
              rspByte_d  = shift_q;
              rspAck_d   = !sdaSync_q;
              rspArb_d   = 1'b0;
              rspValid_d = 1'b1;
              if (!rdMode_q && sdaSync_q) stop_d = 1'b1;
            end else begin
              shift_d = {shift_q[6:0], sdaSync_q};
            end
          end
        end
      end
      ST_PLOW: begin
        cnt_d = cntInc;
        if (atQuarter) sdaOe_d = 1'b1;
        if (atHalf) begin
          sclOe_d = 1'b0;
          cnt_d   = '0;
          state_d = ST_PHIGH;
        end
      end
      ST_PHIGH: begin
        if (sclSync_q) cnt_d = cntInc;
        if (sclSync_q && atHalf) begin
          sdaOe_d = 1'b0;
          own_d   = 1'b0;
          cnt_d   = '0;
          state_d = ST_PDONE;
        end
      end
      ST_PDONE: begin
        cnt_d = cntInc;
        if (atHalf) state_d = ST_IDLE;
      end
    endcase
    // Fresh START only on an idle bus; an owner may always continue
    cmdReady_d = state_d == ST_IDLE && !takeCmd
                 && (own_d || (!busy_d && sclSync_q && sdaSync_q));
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sysClk) begin
    if (!rstn) begin
      sclMeta_q <= 1'b1;
      sclSync_q <= 1'b1;
      sclPrev_q <= 1'b1;
      sdaMeta_q <= 1'b1;
      sdaSync_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else if (clkEn) begin
      sclMeta_q <= busClockPinIn;
      sclSync_q <= sclMeta_q;
      sclPrev_q <= sclSync_q;
      sdaMeta_q <= busDataPinIn;
      sdaSync_q <= sdaMeta_q;
      sdaPrev_q <= sdaSync_q;
    end
  end

  always_ff @(posedge sysClk) begin
    if (!rstn) begin
      state_q    <= ST_IDLE;
      cnt_q      <= '0;
      bitIdx_q   <= '0;
      shift_q    <= BYTE_RESET;
      rdMode_q   <= 1'b0;
      nackLast_q <= 1'b0;
      stop_q     <= 1'b0;
      own_q      <= 1'b0;
      busy_q     <= 1'b0;
      sclOe_q    <= 1'b0;
      sdaOe_q    <= 1'b0;
    end else if (clkEn) begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      bitIdx_q   <= bitIdx_d;
      shift_q    <= shift_d;
      rdMode_q   <= rdMode_d;
      nackLast_q <= nackLast_d;
      stop_q     <= stop_d;
      own_q      <= own_d;
      busy_q     <= busy_d;
      sclOe_q    <= sclOe_d;
      sdaOe_q    <= sdaOe_d;
    end
  end

  always_ff @(posedge sysClk) begin
    if (!rstn) begin
      cmdReady_q <= 1'b0;
      rspValid_q <= 1'b0;
      rspByte_q  <= BYTE_RESET;
      rspAck_q   <= 1'b0;
      rspArb_q   <= 1'b0;
    end else if (clkEn) begin
      cmdReady_q <= cmdReady_d;
      rspValid_q <= rspValid_d;
      rspByte_q  <= rspByte_d;
      rspAck_q   <= rspAck_d;
      rspArb_q   <= rspArb_d;
    end
  end

  // Open drain: the output level is always low, only the enable moves
  assign busClockPinOut = 1'b0;
  assign busDataPinOut  = 1'b0;
  assign busClockPinOe  = sclOe_q;
  assign busDataPinOe   = sdaOe_q;
  assign cmdReady       = cmdReady_q;
  assign rspValid       = rspValid_q;
  assign rspByte        = rspByte_q;
  assign rspAck         = rspAck_q;
  assign rspArbLost     = rspArb_q;
  assign busBusy        = busy_q;

  ////////////////////////////////////////////////////////////////////////////
  sda_stable_a : assert property (@(posedge sysClk) disable iff (!rstn)
    state_q == ST_HIGH && $past(state_q) == ST_HIGH |-> $stable(sdaOe_q))
    else $error("data moved during clock high");
  start_idle_a : assert property (@(posedge sysClk) disable iff (!rstn)
    state_q == ST_HOLD && $past(state_q) == ST_SETUP
    |-> $past(sclSync_q) && $past(sdaSync_q) && !sclOe_q)
    else $error("start without idle lines");
  ack_release_a : assert property (@(posedge sysClk) disable iff (!rstn)
    state_q == ST_HIGH && isAck && !rdMode_q |-> !sdaOe_q)
    else $error("transmitter held data in ack");
  ack_drive_a : assert property (@(posedge sysClk) disable iff (!rstn)
    state_q == ST_HIGH && isAck && rdMode_q |-> sdaOe_q == !nackLast_q)
    else $error("wrong receiver acknowledge");
  stretch_wait_a : assert property (@(posedge sysClk) disable iff (!rstn)
    clkEn && state_q == ST_HIGH && !sclSync_q |=> cnt_q == $past(cnt_q))
    else $error("high phase counted while held low");
  msb_first_a : assert property (@(posedge sysClk) disable iff (!rstn)
    clkEn && state_q == ST_LOW && atQuarter && !isTail && !isAck && !rdMode_q
    |=> sdaOe_q == !$past(shift_q[7]))
    else $error("bit order wrong");
  nine_bits_a : assert property (@(posedge sysClk) disable iff (!rstn)
    rspValid_q && !rspArb_q |-> bitIdx_q == 4'(TAIL_IDX))
    else $error("byte not nine bits");
  nack_stop_a : assert property (@(posedge sysClk) disable iff (!rstn)
    rspValid_q && !rspArb_q && !rspAck_q && !rdMode_q |-> stop_q)
    else $error("no stop after missing ack");
  stop_edge_a : assert property (@(posedge sysClk) disable iff (!rstn)
    state_q == ST_PDONE && $past(state_q) == ST_PHIGH
    |-> $past(sclSync_q) && !sclOe_q && !sdaOe_q)
    else $error("stop not made with clock high");
  arb_release_a : assert property (@(posedge sysClk) disable iff (!rstn)
    rspValid_q && rspArb_q |-> !sdaOe_q && !own_q && state_q == ST_IDLE)
    else $error("kept driving after lost arbitration");
endmodule : twm_bus_host
`default_nettype wire

//--- src/twm_pkg.sv
// Constants and types shared by the two-wire bus host controller
`default_nettype none
package twm_pkg;
  localparam int unsigned SYS_CLK_HZ   = 20_000_000;
  localparam int unsigned STD_RATE_HZ  = 100_000;
  localparam int unsigned FAST_RATE_HZ = 400_000;
  // Bus rate divider: one bit is ten units of 2*(1+divider) clocks
  localparam int unsigned STD_RATE_DIVIDER  = 9;
  // Fast divider rounded up so the bus never exceeds the Fast limit
  localparam int unsigned FAST_RATE_DIVIDER = 2;
  // Timing step of two units: low phase three steps, high phase two
  localparam int unsigned STD_QUARTER  = 4 * (1 + STD_RATE_DIVIDER);
  localparam int unsigned FAST_QUARTER = 4 * (1 + FAST_RATE_DIVIDER);
  localparam int unsigned CNT_W        = 8;
  localparam int unsigned ACK_IDX      = 8;
  localparam int unsigned TAIL_IDX     = 9;
  localparam logic [7:0]  BYTE_RESET   = 8'h00;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_HOLD, ST_LOW, ST_HIGH, ST_PLOW, ST_PHIGH, ST_PDONE
  } twm_state_t;
endpackage : twm_pkg
`default_nettype wire

//--- tb/tb_twm_bus_host.sv
// Self-checking bench for the two-wire bus host
`default_nettype none
module tb_twm_bus_host;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] DEV = 7'h3B;
  localparam logic [7:0] TXB = 8'h3C;
  logic       sysClk = 1'b0, rstn = 1'b0, fastMode = 1'b0, cmdValid = 1'b0;
  logic       cmdStart = 1'b0, cmdStop = 1'b0, cmdRead = 1'b0;
  logic       cmdNack = 1'b0, compete = 1'b0;
  logic [6:0] cmdAddr = 7'h00;
  logic [7:0] cmdByte = 8'h00, stretch = 8'h00;
  logic       cmdReady, rspValid, rspAck, rspArbLost, busBusy;
  logic [7:0] rspByte, devRx;
  logic       hSclOe, hSdaOe, dSclOe, dSdaOe, devAck, devOn;
  wire        sclLine = !(hSclOe || dSclOe);
  wire        sdaLine = !(hSdaOe || dSdaOe);
  int         n_errors = 0, checks_done = 0, cycles = 0;
  twm_bus_host #(.STD_Q(4), .FAST_Q(2)) twm_bus_host_i (
    .sysClk(sysClk), .rstn(rstn), .clkEn(1'b1), .fastMode(fastMode),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdStart(cmdStart),
    .cmdStop(cmdStop), .cmdRead(cmdRead), .cmdNack(cmdNack),
    .cmdAddr(cmdAddr), .cmdByte(cmdByte), .rspValid(rspValid),
    .rspByte(rspByte), .rspAck(rspAck), .rspArbLost(rspArbLost),
    .busBusy(busBusy), .busClockPinIn(sclLine), .busClockPinOut(),
    .busClockPinOe(hSclOe), .busDataPinIn(sdaLine), .busDataPinOut(),
    .busDataPinOe(hSdaOe));
  twm_dev_model #(.DEV_ADDR(DEV), .TX_FIRST(TXB)) twm_dev_model_i (
    .sysClk(sysClk), .rstn(rstn), .stretch(stretch), .compete(compete),
    .scl(sclLine), .sda(sdaLine), .sclOe(dSclOe), .sdaOe(dSdaOe),
    .rxByte(devRx), .mstAck(devAck), .busOn(devOn));
  initial begin
    forever #25 sysClk = ~sysClk;
  end
  // Whole run needs a few thousand cycles
  always @(posedge sysClk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      final_report;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  task automatic check(input string what, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One byte command; held until taken, then wait for its response
  task automatic send(input logic s, p, r, k, input logic [6:0] a,
                      input logic [7:0] b);
    int i;
    i = 0;
    @(posedge sysClk);
    cmdValid <= 1'b1;
    cmdStart <= s;
    cmdStop <= p;
    cmdRead <= r;
    cmdNack <= k;
    cmdAddr <= a;
    cmdByte <= b;
    do begin
      @(posedge sysClk);
      i++;
    end while (cmdReady !== 1'b1 && i < 4000);
    cmdValid <= 1'b0;
    do begin
      @(posedge sysClk);
      i++;
    end while (rspValid !== 1'b1 && i < 8000);
    check("rsp", {7'h00, rspValid}, 8'h01);
  endtask : send
  task automatic wait_idle;
    int i;
    for (i = 0; i < 3000 && busBusy !== 1'b0; i++) @(posedge sysClk);
    check("busy", {7'h00, busBusy}, 8'h00);
    check("dev busy", {7'h00, devOn}, 8'h00);
  endtask : wait_idle
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check("ready", {7'h00, cmdReady}, 8'h00);
    check("pins", {6'h00, hSclOe, hSdaOe}, 8'h00);
    check("busy", {7'h00, busBusy}, 8'h00);
  endtask : t_reset
  task automatic t_write;
    send(1'b1, 1'b0, 1'b0, 1'b0, DEV, 8'h00);
    check("addr ack", {7'h00, rspAck}, 8'h01);
    check("busy", {7'h00, busBusy}, 8'h01);
    send(1'b0, 1'b1, 1'b0, 1'b0, DEV, 8'hA5);
    check("data ack", {7'h00, rspAck}, 8'h01);
    wait_idle;
    check("dev byte", devRx, 8'hA5);
  endtask : t_write
  // Restart into a read, Fast rate, device stretching the clock
  task automatic t_read;
    fastMode <= 1'b1;
    stretch <= 8'h28;
    send(1'b1, 1'b0, 1'b0, 1'b0, DEV, 8'h00);
    send(1'b1, 1'b0, 1'b1, 1'b0, DEV, 8'h00);
    check("rd ack", {7'h00, rspAck}, 8'h01);
    send(1'b0, 1'b0, 1'b1, 1'b0, DEV, 8'h00);
    check("rd 1", rspByte, TXB);
    check("mst ack", {7'h00, devAck}, 8'h01);
    send(1'b0, 1'b1, 1'b1, 1'b1, DEV, 8'h00);
    check("rd 2", rspByte, TXB + 8'h01);
    check("mst nack", {7'h00, devAck}, 8'h00);
    wait_idle;
    fastMode <= 1'b0;
    stretch <= 8'h00;
  endtask : t_read
  task automatic t_nack;
    send(1'b1, 1'b0, 1'b0, 1'b0, 7'h2A, 8'h00);
    check("nack", {7'h00, rspAck}, 8'h00);
    check("no arb", {7'h00, rspArbLost}, 8'h00);
    wait_idle;
  endtask : t_nack
  task automatic t_arb;
    compete <= 1'b1;
    send(1'b1, 1'b0, 1'b0, 1'b0, 7'h55, 8'h00);
    check("arb lost", {7'h00, rspArbLost}, 8'h01);
    check("arb ack", {7'h00, rspAck}, 8'h00);
    repeat (20) @(posedge sysClk);
    check("let go", {6'h00, hSclOe, hSdaOe}, 8'h00);
    check("wait idle", {7'h00, cmdReady}, 8'h00);
    compete <= 1'b0;
    wait_idle;
  endtask : t_arb
  initial begin
    repeat (6) @(posedge sysClk);
    t_reset;
    rstn <= 1'b1;
    t_write;
    t_read;
    t_nack;
    t_arb;
    t_write;
    final_report;
  end
endmodule : tb_twm_bus_host
`default_nettype wire

//--- tb/twm_dev_model.sv
// Slave device model on the open-drain two-wire bus
`default_nettype none
module twm_dev_model #(
  parameter logic [6:0] DEV_ADDR = 7'h3B,
  parameter logic [7:0] TX_FIRST = 8'h3C
) (
  // Clock and reset
  input  wire logic       sysClk,
  input  wire logic       rstn,
  // Test controls
  input  wire logic [7:0] stretch,
  input  wire logic       compete,
  // Wired levels and pull-downs
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sclOe,
  output logic            sdaOe,
  // Observed traffic
  output logic [7:0]      rxByte,
  output logic            mstAck,
  output logic            busOn
);
  logic       sclQ, sdaQ, isAddr, sel, rd, ackNx, go, cmpQ, drvQ;
  logic [3:0] bitCnt;
  logic [7:0] sh, tx, hold;
  wire        rise    = !sclQ && scl;
  wire        fall    = sclQ && !scl;
  wire        startEv = scl && sclQ && sdaQ && !sda;
  wire        stopEv  = scl && sclQ && !sdaQ && sda;
  wire  [7:0] byteIn  = {sh[6:0], sda};
  wire        hit     = byteIn[7:1] == DEV_ADDR;
  assign sclOe = hold != 8'h00;
  // A competing master pulls data low from START until compete drops
  assign sdaOe = drvQ || cmpQ;
  always_ff @(posedge sysClk) begin
    sclQ <= scl;
    sdaQ <= sda;
    if (hold != 8'h00) hold <= hold - 8'h01;
    if (!compete) cmpQ <= 1'b0;
    if (startEv) begin
      busOn <= 1'b1;
      bitCnt <= 4'h0;
      isAddr <= 1'b1;
      sel <= 1'b0;
      cmpQ <= compete;
    end
    if (stopEv) begin
      busOn <= 1'b0;
      drvQ <= 1'b0;
    end
    if (rise && busOn) begin
      sh <= byteIn;
      bitCnt <= (bitCnt == 4'h8) ? 4'h0 : bitCnt + 4'h1;
      if (bitCnt == 4'h7 && isAddr) begin
        sel <= hit;
        rd <= byteIn[0];
        ackNx <= hit;
      end
      if (bitCnt == 4'h7 && !isAddr) begin
        ackNx <= sel && !rd;
        if (sel && !rd) rxByte <= byteIn;
      end
      if (bitCnt == 4'h8) begin
        isAddr <= 1'b0;
        mstAck <= !sda;
        go <= isAddr ? ackNx : !sda;
        if (sel && rd && !isAddr) tx <= tx + 8'h01;
      end
    end
    // Data changes only just after clock falls
    if (fall && busOn) begin
      if (bitCnt == 4'h8) drvQ <= ackNx;
      else drvQ <= sel && rd && go && !isAddr && !tx[3'd7 - bitCnt[2:0]];
      if (bitCnt == 4'h0) hold <= stretch;
    end
    if (!rstn) begin
      sclQ <= 1'b1;
      sdaQ <= 1'b1;
      busOn <= 1'b0;
      drvQ <= 1'b0;
      cmpQ <= 1'b0;
      hold <= 8'h00;
      sel <= 1'b0;
      tx <= TX_FIRST;
    end
  end
endmodule : twm_dev_model
`default_nettype wire
